// [inc/arss_defs.vh]
`ifndef ARSS_DEFS_VH
`define ARSS_DEFS_VH
// reference selection codes
`define ARSS_REF_EXT 2'h0
`define ARSS_REF_SUPPLY 2'h1
`define ARSS_REF_INT 2'h3
// result widths and limits
`define ARSS_RES_W 10
`define ARSS_SE_MAX 10'h3ff
`define ARSS_SE_MIN 10'h000
`define ARSS_DIFF_MAX 10'h1ff
`define ARSS_DIFF_MIN 10'h200
`define ARSS_SIGN_POS 9
// byte presentation
`define ARSS_BYTE_W 8
`define ARSS_BYTE_ZERO 8'h00
`define ARSS_LJ_PAD 6'h00
`define ARSS_RJ_PAD 6'h00
// raw input widths: single-ended 11 bits, differential 12 bits signed
`define ARSS_SE_RAW_W 11
`define ARSS_DF_RAW_W 12
// sleep state codes
`define ARSS_SLP_NONE 2'h0
`define ARSS_SLP_IDLE 2'h1
`define ARSS_SLP_QUIET 2'h2
`define ARSS_SLP_OTHER 2'h3
`endif

// [hw/arss_result_sleep.v]
// Function
// [R01] hold result in low/high bytes when done
// [R02] single-ended code is vin*1024/vref
// [R03] 0x000 ground, 0x3ff reference minus one
// [R04] overrange single-ended input clamps at 0x3ff
// [R05] differential code is diff*gain*512/vref
// [R06] differential two's complement 0x200 to 0x1ff
// [R07] top result bit flags negative difference
// [R08] reference from supply, internal or pin
// [R09] software enables, idles, single mode, irq on
// [R10] quiet or idle sleep starts conversion
// [R11] completion interrupt wakes halted processor
// [R12] other wake lets conversion finish, irq raised
// [R13] no auto disable in other sleep states
// [R14] software clears enable before deep sleep
// [R15] software re-enables for differential after wake
// [R16] software discards first result after switch
// [R17] software measures offset with same channels
// [R18] port pins quiet during conversion
// [R19] result and done flag set together; result bytes and sign bit follow the flag one clock later
// [R20] left-justify bit aligns result left
// [R21] result held until next completion
`timescale 1ns/10ps
`include "arss_defs.vh"
module arss_result_sleep (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_converter_enable_bit,
    input wire i_left_justify_bit,
    input wire i_differential,
    input wire [1:0] i_ref_select,
    input wire i_single_mode,
    input wire i_irq_enable,
    input wire i_start,
    input wire i_flag_clear,
    input wire [1:0] i_sleep_state,
    input wire i_cpu_halted,
    input wire i_conv_done,
    input wire [`ARSS_SE_RAW_W-1:0] i_se_raw,
    input wire signed [`ARSS_DF_RAW_W-1:0] i_df_raw,
    output reg o_conv_start,
    output reg o_busy,
    output reg [1:0] o_ref_sel,
    output reg [7:0] o_result_low_byte,
    output reg [7:0] o_result_high_byte,
    output reg o_result_sign_bit,
    output reg o_conversion_done_flag,
    output reg o_irq,
    output reg o_wake
);
    reg [`ARSS_RES_W-1:0] result_r;
    reg [`ARSS_RES_W-1:0] code_nxt;
    reg sleep_arm_r;
    reg sleep_arm_nxt;
    reg conv_start_nxt;
    reg busy_nxt;
    reg [1:0] ref_sel_nxt;
    reg flag_nxt;
    reg irq_nxt;
    reg wake_nxt;
    reg [2*`ARSS_BYTE_W-1:0] bytes_nxt;
    wire [`ARSS_RES_W-1:0] se_code_w;
    wire [`ARSS_RES_W-1:0] df_code_w;
    wire quiet_sleep;
    wire sleep_start;
    wire done;

    // clamp single-ended raw count into code range
    function [`ARSS_RES_W-1:0] se_code;
        input [`ARSS_SE_RAW_W-1:0] raw;
        begin
            if (raw > {1'b0, `ARSS_SE_MAX}) begin
                se_code = `ARSS_SE_MAX; // R04
            end else begin
                se_code = raw[`ARSS_RES_W-1:0]; // R02 R03
            end
        end
    endfunction

    // saturate signed differential count into two's complement code
    function [`ARSS_RES_W-1:0] df_code;
        input signed [`ARSS_DF_RAW_W-1:0] raw;
        begin
            if (raw > $signed({2'b00, `ARSS_DIFF_MAX})) begin
                df_code = `ARSS_DIFF_MAX; // R06
            end else if (raw < $signed({2'b11, `ARSS_DIFF_MIN})) begin
                df_code = `ARSS_DIFF_MIN; // R06
            end else begin
                df_code = raw[`ARSS_RES_W-1:0]; // R05
            end
        end
    endfunction

    // place the code across the two bytes per justify bit
    function [2*`ARSS_BYTE_W-1:0] place_bytes;
        input [`ARSS_RES_W-1:0] code;
        input left;
        begin
            if (left) begin
                place_bytes = {code, `ARSS_LJ_PAD}; // R20
            end else begin
                place_bytes = {`ARSS_RJ_PAD, code}; // R20
            end
        end
    endfunction

    assign se_code_w = se_code(i_se_raw);
    assign df_code_w = df_code(i_df_raw);

    assign quiet_sleep = (i_sleep_state == `ARSS_SLP_IDLE) ||
                         (i_sleep_state == `ARSS_SLP_QUIET);
    // start once halted in a quiet state, with software preconditions
    assign sleep_start = quiet_sleep && i_cpu_halted && sleep_arm_r &&
                         i_converter_enable_bit && !o_busy &&
                         i_single_mode && i_irq_enable; // R10 R09
    assign done = o_busy && i_conv_done && i_converter_enable_bit;

    // pick the code of the active input kind
    always @* begin
        if (i_differential) begin
            code_nxt = df_code_w;
        end else begin
            code_nxt = se_code_w;
        end
    end

    // start pulse; one auto start per sleep entry, rearm when awake
    always @* begin
        conv_start_nxt = (i_start || sleep_start) && !o_busy &&
                         i_converter_enable_bit;
        sleep_arm_nxt = sleep_arm_r;
        if (sleep_start) begin
            sleep_arm_nxt = 1'b0;
        end else if (!i_cpu_halted) begin
            sleep_arm_nxt = 1'b1;
        end
    end

    // enable only drops by software, never by sleep state
    always @* begin
        busy_nxt = o_busy;
        if (!i_converter_enable_bit) begin
            busy_nxt = 1'b0; // R13
        end else if (o_conv_start) begin
            busy_nxt = 1'b1;
        end else if (done) begin
            busy_nxt = 1'b0;
        end
        // reference locked while converting
        ref_sel_nxt = o_ref_sel;
        if (!o_busy) begin
            ref_sel_nxt = i_ref_select; // R08
        end
    end

    // set wins over clear; request raised whoever woke the processor
    always @* begin
        flag_nxt = o_conversion_done_flag;
        if (done) begin
            flag_nxt = 1'b1; // R19
        end else if (i_flag_clear) begin
            flag_nxt = 1'b0;
        end
        irq_nxt = flag_nxt && i_irq_enable; // R12
        wake_nxt = done && i_irq_enable && i_cpu_halted; // R11
    end

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sleep_arm_r <= 1'b1;
            o_conv_start <= 1'b0;
            o_busy <= 1'b0;
            o_ref_sel <= `ARSS_REF_EXT;
            o_conversion_done_flag <= 1'b0;
            o_irq <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            o_conv_start <= conv_start_nxt;
            sleep_arm_r <= sleep_arm_nxt;
            o_busy <= busy_nxt;
            o_ref_sel <= ref_sel_nxt;
            o_conversion_done_flag <= flag_nxt;
            o_irq <= irq_nxt;
            o_wake <= wake_nxt;
        end
    end

    // result kept until the next completion
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            result_r <= `ARSS_SE_MIN;
        end else begin
            if (done) begin
                result_r <= code_nxt; // R19 R21 R01
            end
        end
    end

    // byte presentation follows justify bit on the next clock edge
    always @* begin
        bytes_nxt = place_bytes(result_r, i_left_justify_bit);
    end

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_result_low_byte <= `ARSS_BYTE_ZERO;
            o_result_high_byte <= `ARSS_BYTE_ZERO;
            o_result_sign_bit <= 1'b0;
        end else begin
            o_result_low_byte <= bytes_nxt[`ARSS_BYTE_W-1:0]; // R20
            o_result_high_byte <=
                bytes_nxt[2*`ARSS_BYTE_W-1:`ARSS_BYTE_W]; // R20
            o_result_sign_bit <= result_r[`ARSS_SIGN_POS]; // R07
        end
    end
endmodule // arss_result_sleep

// [dv/arss_result_sleep_props.sv]
`timescale 1ns/10ps
module arss_props_chk (
    input wire i_clock, i_rst_n, i_left_justify_bit, i_conv_done,
    input wire i_differential, o_busy, o_result_sign_bit, o_wake,
    input wire o_conversion_done_flag,
    input wire i_converter_enable_bit, o_conv_start,
    input wire [10:0] i_se_raw,
    input wire signed [11:0] i_df_raw,
    input wire [1:0] o_ref_sel,
    input wire [7:0] o_result_low_byte, o_result_high_byte
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    done_flag_a: assert property (o_busy && i_conv_done &&
        i_converter_enable_bit |=>
        o_conversion_done_flag && !o_busy) else $error("no flag");
    right_al_a: assert property (!$past(i_left_justify_bit) &&
        !$past(i_left_justify_bit, 2) |-> o_result_high_byte[7:2] == 6'h0)
        else $error("not right aligned");
    left_al_a: assert property ($past(i_left_justify_bit) &&
        $past(i_left_justify_bit, 2) |-> o_result_low_byte[5:0] == 6'h0)
        else $error("not left aligned");
    hold_res_a: assert property (!i_conv_done ##1 !i_conv_done &&
        $stable(i_left_justify_bit) |=> $stable({o_result_high_byte,
        o_result_low_byte})) else $error("result moved");
    diff_sign_a: assert property (o_busy && i_conv_done &&
        i_converter_enable_bit && i_differential |-> ##2
        o_result_sign_bit == $past(i_df_raw[11], 2))
        else $error("bad sign");
    se_clamp_a: assert property (o_busy && i_conv_done &&
        i_converter_enable_bit && !i_differential && i_se_raw[10]
        |-> ##2 o_result_sign_bit) else $error("no clamp");
    start_busy_a: assert property (o_conv_start &&
        i_converter_enable_bit |=> o_busy) else $error("no busy");
    off_idle_a: assert property (!i_converter_enable_bit |=>
        !o_busy) else $error("busy while off");
    wake_flag_a: assert property (o_wake |->
        o_conversion_done_flag) else $error("wake without flag");
    ref_hold_a: assert property (o_busy && $past(o_busy) |->
        $stable(o_ref_sel)) else $error("reference moved");
endmodule // arss_props_chk
bind arss_result_sleep arss_props_chk u_props (.*);

// [dv/arss_analog_model.sv]
`timescale 1ns/10ps
module arss_analog_model #(parameter int DLY = 13) (
    input wire i_clock,
    input wire i_conv_start,
    output logic o_conv_done = 0
);
    int cnt = 0;
    // finishes a fixed number of cycles after each start
    always @(posedge i_clock) begin
        cnt <= i_conv_start ? DLY : (cnt > 0 ? cnt - 1 : 0);
        o_conv_done <= #1 (cnt == 1);
    end
endmodule // arss_analog_model

// [dv/arss_result_sleep_tb.sv]
`timescale 1ns/10ps
module arss_result_sleep_tb;
    logic i_clock = 0, i_rst_n = 0, lj = 0, dif = 0, st = 0, clr = 0;
    logic halt = 0, done, wk, cs, busy, sg, flag, irq;
    logic en = 1, sm = 1, ie = 1;
    logic [1:0] slp = 0, rs, rfs = 2'h3;
    logic [10:0] se = 0;
    logic signed [11:0] df = 0;
    logic [7:0] lo, hi;
    int n_errors = 0, check_count = 0, cyc = 0, n_wake = 0;
    arss_result_sleep dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_converter_enable_bit(en), .i_left_justify_bit(lj),
        .i_differential(dif), .i_ref_select(rfs), .i_single_mode(sm),
        .i_irq_enable(ie), .i_start(st), .i_flag_clear(clr),
        .i_sleep_state(slp), .i_cpu_halted(halt), .i_conv_done(done),
        .i_se_raw(se), .i_df_raw(df), .o_conv_start(cs), .o_busy(busy),
        .o_ref_sel(rs), .o_result_low_byte(lo), .o_result_high_byte(hi),
        .o_result_sign_bit(sg), .o_conversion_done_flag(flag),
        .o_irq(irq), .o_wake(wk));
    arss_analog_model ana_u (.i_clock(i_clock), .i_conv_start(cs),
        .o_conv_done(done));
    initial forever #5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (wk) n_wake <= n_wake + 1;
        if (cyc == 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wflag();
        for (int k = 0; k < 40 && flag !== 1'b1; k++) begin
            @(posedge i_clock);
            #1;
        end
        @(posedge i_clock);
        #1;
    endtask
    task automatic conv(input logic d, input logic [10:0] s,
        input logic signed [11:0] f, input logic [9:0] r);
        dif = d; se = s; df = f; clr = 1;
        @(posedge i_clock);
        #1 clr = 0; st = 1;
        @(posedge i_clock);
        #1 st = 0;
        wflag();
        chk("right", {hi, lo}, {6'h0, r});
        chk("sign", sg, r[9]);
        chk("irq", irq, 1);
        chk("busy", busy, 0);
        chk("ref", rs, rfs);
        lj = 1;
        repeat (2) @(posedge i_clock);
        #1 chk("left", {hi, lo}, {r, 6'h0});
        lj = 0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        #1 i_rst_n = 1;
        conv(0, 11'h3ff, 0, 10'h3ff);
        conv(0, 11'h5a0, 0, 10'h3ff);
        conv(1, 0, 12'sh000, 10'h000);
        conv(1, 0, -12'sd400, 10'h270);
        conv(1, 0, 12'sd600, 10'h1ff);
        conv(1, 0, -12'sd700, 10'h200);
        $display("conversion test done");
        clr = 1; slp = 2'h2; halt = 1;
        @(posedge i_clock);
        #1 clr = 0;
        wflag();
        chk("wake", n_wake, 1);
        chk("flag", flag, 1);
        clr = 1; halt = 0; slp = 2'h1;
        @(posedge i_clock);
        #1 clr = 0; halt = 1;
        repeat (4) @(posedge i_clock);
        #1 halt = 0; rfs = 2'h1;
        wflag();
        chk("irq", irq, 1);
        chk("no wake", n_wake, 1);
        chk("ref", rs, 2'h1);
        $display("sleep test done");
        halt = 0; slp = 2'h3; clr = 1;
        @(posedge i_clock);
        #1 clr = 0; halt = 1; st = 1;
        @(posedge i_clock);
        #1 st = 0;
        repeat (3) @(posedge i_clock);
        #1 chk("busy on", busy, 1);
        en = 0;
        @(posedge i_clock);
        #1 chk("abort", busy, 0);
        repeat (20) @(posedge i_clock);
        #1 chk("no flag", flag, 0);
        en = 1; halt = 0; slp = 2'h0;
        conv(1, 0, 12'sd5, 10'h005);
        conv(1, 0, 12'sd5, 10'h005);
        $display("enable test done");
        i_rst_n = 0;
        @(posedge i_clock);
        #1 chk("rst flag", flag, 0);
        chk("rst bytes", {hi, lo}, 16'h0000);
        chk("rst ref", rs, 2'h0);
        i_rst_n = 1;
        repeat (2) @(posedge i_clock);
        #1 chk("ref again", rs, 2'h1);
        $display("reset test done");
        print_verdict();
    end
endmodule // arss_result_sleep_tb
